//--- hw/tsrs_pkg.sv
package tsrs_pkg;

   // Register selector codes, as held in the pointer.
   localparam logic [1:0] PTR_MEASURED = 2'h0;
   localparam logic [1:0] PTR_SETTINGS = 2'h1;
   localparam logic [1:0] PTR_LOWER    = 2'h2;
   localparam logic [1:0] PTR_UPPER    = 2'h3;

   // Field positions within the settings byte.
   localparam int SHUTDOWN_CTL_BIT     = 0;
   localparam int ALERT_TYPE_BIT       = 1;
   localparam int OUTPUT_LEVEL_SEL_BIT = 2;
   localparam int FAULT_COUNT_LO_BIT   = 3;
   localparam int FAULT_COUNT_HI_BIT   = 4;

   // Writable bits of the settings byte; bit 7 is reserved read-only.
   localparam logic [7:0] SETTINGS_WR_MASK = 8'h7F;
   localparam logic [7:0] SETTINGS_RESET   = 8'h00;

   // Temperature word layout.
   localparam int TEMP_WIDTH  = 9;
   localparam int TEMP_TOP    = 15;
   localparam int TEMP_BOTTOM = 7;

   // Reset values of the words.
   localparam logic [15:0] MEASURED_RESET = 16'h0000;
   localparam logic [15:0] UPPER_RESET    = 16'h5000;
   localparam logic [15:0] LOWER_RESET    = 16'h4B00;

   // Fault count thresholds for codes 00, 01, 10 and 11.
   localparam logic [2:0] FAULTS_CODE0 = 3'h1;
   localparam logic [2:0] FAULTS_CODE1 = 3'h2;
   localparam logic [2:0] FAULTS_CODE2 = 3'h4;
   localparam logic [2:0] FAULTS_CODE3 = 3'h6;

   // Register access request from the serial engine.
   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [1:0]  sel;
      logic [15:0] wdata;
   } tsrs_req_s;

   // Conversion result from the converter.
   typedef struct packed
   {
      logic                  done;
      logic [TEMP_WIDTH-1:0] value;
   } tsrs_conv_s;

endpackage

//--- hw/tsrs_fault_count.sv
`timescale 1ns/1ps
// Counts consecutive threshold violations and flags when the
// programmed number is reached.
module tsrs_fault_count
   import tsrs_pkg::*;
(
   // Clock and reset.
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   // Sample stream.
   input  wire logic       sample_i,
   input  wire logic       hit_i,
   input  wire logic       clear_i,
   input  wire logic [1:0] code_i,
   // Result.
   output logic            reached_o
);

   logic [2:0] count;
   logic [2:0] next_count;
   logic [2:0] need;

   // Translates the fault count code into the run length needed.
   always_comb
   begin
      unique case (code_i)
         2'h0: need = FAULTS_CODE0;
         2'h1: need = FAULTS_CODE1;
         2'h2: need = FAULTS_CODE2;
         2'h3: need = FAULTS_CODE3;
      endcase
   end

   // A miss restarts the run; the count saturates at the need.
   always_comb
   begin
      next_count = count;
      if (clear_i)
         next_count = 3'h0;
      else if (sample_i && !hit_i)
         next_count = 3'h0;
      else if (sample_i && count < need)
         next_count = count + 3'h1;
   end

   // Run length register.
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         count <= 3'h0;
      else
         count <= next_count;
   end

   // Reached counts the sample now being taken, so a miss can never
   // complete a run that an earlier hit had filled.
   assign reached_o = (next_count >= need);

endmodule

//--- hw/tsrs_limit_cmp.sv
`timescale 1ns/1ps
// Signed compare of a 9-bit temperature against the top bits of
// a trip word; the low bits of the word are ignored.
module tsrs_limit_cmp
   import tsrs_pkg::*;
(
   // Operands.
   input  wire logic [TEMP_WIDTH-1:0] temp_i,
   input  wire logic [15:0]           limit_i,
   // Results.
   output logic                       above_o,
   output logic                       below_o
);

   logic signed [TEMP_WIDTH-1:0] t;
   logic signed [TEMP_WIDTH-1:0] l;

   // Only bits 15 down to 7 take part.
   assign t = temp_i;
   assign l = limit_i[TEMP_TOP:TEMP_BOTTOM];
   assign above_o = (t > l);
   assign below_o = (t < l);

endmodule

//--- hw/tsrs_regs.sv
`timescale 1ns/1ps
// Contract
// - Settings bits writable except reserved bit 7.
// - Settings register clears to zero at reset.
// - Shutdown, alert type, polarity, fault count positions.
// - Alert type 0 comparator, 1 interrupt.
// - Fault codes need 1, 2, 4, 6 violations.
// - Shutdown finishes conversion, clears interrupt alarm.
// - Interrupt alarm cleared by read or shutdown.
// - Temperatures are 9-bit, half-degree two's complement.
// - Measured value read-only, refreshed per conversion.
// - Measured value readable at any time.
// - Compare buffer always loads; readable copy skipped during a read.
// - Alarm evaluation ignores bus traffic.
// - Conversion during read keeps previous value.
// - Sign bit 15, top bit 14, bottom 7.
// - Measured value clears to zero at reset.
// - Upper trip limit resets to 80 degrees.
// - Lower trip limit resets to 75 degrees.
// - Compare only top nine bits of limits.
module tsrs_regs
   import tsrs_pkg::*;
(
   // Clock and reset.
   input  wire logic                mclk_i,
   input  wire logic                rst_b_i,
   // Register access from the serial engine.
   input  wire tsrs_pkg::tsrs_req_s req_i,
   input  wire logic                rd_busy_i,
   output logic [15:0]              rdata_o,
   // Converter side.
   input  wire tsrs_pkg::tsrs_conv_s conv_i,
   output logic                     conv_run_o,
   // Alarm pin, open drain; enable low drives the pin low.
   output logic                     alarm_out_o,
   output logic                     alarm_out_oe_b_o,
   // Settings and state visible to the core.
   output logic [7:0]               settings_o,
   output logic                     standby_o
);

   // Writes a settings byte keeping the reserved bit at zero.
   function automatic logic [7:0] settings_merge(input logic [7:0] w);
      settings_merge = w & SETTINGS_WR_MASK;
   endfunction

   // Places a 9-bit temperature into the 16-bit word layout.
   function automatic logic [15:0] temp_word(
      input logic [TEMP_WIDTH-1:0] v);
      temp_word = {v, {TEMP_BOTTOM{1'b0}}};
   endfunction

   // Register state.
   logic [7:0]            settings;
   logic [7:0]            next_settings;
   logic [15:0]           measured_value;
   logic [15:0]           next_measured_value;
   logic [15:0]           upper_trip_limit;
   logic [15:0]           next_upper_trip_limit;
   logic [15:0]           lower_trip_limit;
   logic [15:0]           next_lower_trip_limit;
   logic [TEMP_WIDTH-1:0] cmp_buf;
   logic [TEMP_WIDTH-1:0] next_cmp_buf;
   logic                  cmp_fresh;
   logic                  next_cmp_fresh;
   logic [15:0]           rdata;
   logic [15:0]           next_rdata;

   // Alarm state.
   logic alarm_active;
   logic next_alarm_active;
   logic armed_high;
   logic next_armed_high;
   logic standby;
   logic next_standby;
   logic next_alarm_pin;

   // Field views of the settings byte.
   logic       shutdown_ctl;
   logic       alert_type;
   logic       output_level_sel;
   logic [1:0] fault_count;

   assign shutdown_ctl     = settings[SHUTDOWN_CTL_BIT];
   assign alert_type       = settings[ALERT_TYPE_BIT];
   assign output_level_sel = settings[OUTPUT_LEVEL_SEL_BIT];
   assign fault_count      = {settings[FAULT_COUNT_HI_BIT],
                              settings[FAULT_COUNT_LO_BIT]};

   // Comparison results and fault runs.
   logic above_upper;
   logic below_upper;
   logic above_lower;
   logic below_lower;
   logic over_hit;
   logic under_hit;
   logic over_reached;
   logic under_reached;
   logic sample;
   logic read_any;
   logic int_clear;

   // The buffer is 9-bit two's complement, half a degree per step.
   tsrs_limit_cmp u_cmp_upper
   (
      .temp_i  (cmp_buf),
      .limit_i (upper_trip_limit),
      .above_o (above_upper),
      .below_o (below_upper)
   );

   // The lower limit only ever ends or starts a run below it.
   tsrs_limit_cmp u_cmp_lower
   (
      .temp_i  (cmp_buf),
      .limit_i (lower_trip_limit),
      .above_o (above_lower),
      .below_o (below_lower)
   );

   // Evaluate once per fresh sample, whatever the bus does.
   assign sample    = cmp_fresh;
   assign over_hit  = above_upper;
   assign under_hit = below_lower;
   assign read_any  = req_i.rd;
   // A held shutdown bit keeps clearing an interrupt alarm.
   assign int_clear = alert_type && (read_any || shutdown_ctl);

   // Each run counter reports on the sample now being taken, so a
   // completed run acts on the edge of its last violation.
   tsrs_fault_count u_run_over
   (
      .mclk_i    (mclk_i),
      .rst_b_i   (rst_b_i),
      .sample_i  (sample),
      .hit_i     (over_hit),
      .clear_i   (1'b0),
      .code_i    (fault_count),
      .reached_o (over_reached)
   );

   tsrs_fault_count u_run_under
   (
      .mclk_i    (mclk_i),
      .rst_b_i   (rst_b_i),
      .sample_i  (sample),
      .hit_i     (under_hit),
      .clear_i   (1'b0),
      .code_i    (fault_count),
      .reached_o (under_reached)
   );

   // Register writes and the conversion capture path.
   always_comb
   begin
      next_settings         = settings;
      next_upper_trip_limit = upper_trip_limit;
      next_lower_trip_limit = lower_trip_limit;
      next_measured_value   = measured_value;
      next_cmp_buf          = cmp_buf;
      next_cmp_fresh        = 1'b0;
      if (req_i.wr)
      begin
         unique case (req_i.sel)
            PTR_SETTINGS:
               next_settings = settings_merge(req_i.wdata[7:0]);
            PTR_UPPER:
               next_upper_trip_limit = req_i.wdata;
            PTR_LOWER:
               next_lower_trip_limit = req_i.wdata;
            // The measured word is read-only; a write is dropped.
            PTR_MEASURED:
               next_measured_value = measured_value;
         endcase
      end
      // Every finished conversion feeds the compare buffer.
      if (conv_i.done)
      begin
         next_cmp_buf   = conv_i.value;
         next_cmp_fresh = 1'b1;
         // The readable copy loads only on a quiet bus; a result that
         // lands inside a read reaches the alarm logic only.
         if (!rd_busy_i)
            next_measured_value = temp_word(conv_i.value);
      end
   end

   // Read data multiplexer, registered; any register at any time.
   // The measured word never waits on the converter.
   always_comb
   begin
      next_rdata = rdata;
      if (req_i.rd)
      begin
         unique case (req_i.sel)
            PTR_MEASURED: next_rdata = measured_value;
            PTR_SETTINGS: next_rdata = {8'h00, settings};
            PTR_UPPER:    next_rdata = upper_trip_limit;
            PTR_LOWER:    next_rdata = lower_trip_limit;
         endcase
      end
   end

   // Alarm behaviour in both modes.
   // A mode change keeps the current alarm state.
   always_comb
   begin
      next_alarm_active = alarm_active;
      next_armed_high   = armed_high;
      if (!alert_type)
      begin
         // Comparator: on above upper, off below lower; between
         // the limits the pin keeps its level.
         next_armed_high = 1'b1;
         if (sample && over_reached)
            next_alarm_active = 1'b1;
         else if (sample && under_reached)
            next_alarm_active = 1'b0;
      end
      else
      begin
         // Interrupt: alternate upper and lower events; clear on
         // read or shutdown.
         // An event beats a clear that falls on the same cycle.
         if (sample && armed_high && over_reached && !alarm_active)
         begin
            next_alarm_active = 1'b1;
            next_armed_high   = 1'b0;
         end
         else if (sample && !armed_high && under_reached
                  && !alarm_active)
         begin
            next_alarm_active = 1'b1;
            next_armed_high   = 1'b1;
         end
         else if (int_clear)
            next_alarm_active = 1'b0;
      end
   end

   // Standby begins after the conversion in progress has finished.
   // The converter run flag drops on the same edge.
   always_comb
   begin
      next_standby = standby;
      if (!shutdown_ctl)
         next_standby = 1'b0;
      else if (conv_i.done)
         next_standby = 1'b1;
   end

   // Pin level follows polarity; with the reset polarity an idle
   // alarm leaves the pin released.
   always_comb
   begin
      next_alarm_pin = output_level_sel ? next_alarm_active
                                        : !next_alarm_active;
   end

   // Register state; every word comes up at its power-up value.
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         settings         <= SETTINGS_RESET;
         measured_value   <= MEASURED_RESET;
         upper_trip_limit <= UPPER_RESET;
         lower_trip_limit <= LOWER_RESET;
         cmp_buf          <= '0;
         cmp_fresh        <= 1'b0;
         rdata            <= 16'h0000;
      end
      else
      begin
         settings         <= next_settings;
         measured_value   <= next_measured_value;
         upper_trip_limit <= next_upper_trip_limit;
         lower_trip_limit <= next_lower_trip_limit;
         cmp_buf          <= next_cmp_buf;
         cmp_fresh        <= next_cmp_fresh;
         rdata            <= next_rdata;
      end
   end

   // Alarm state; the alarm comes up idle and armed for the upper limit.
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         alarm_active <= 1'b0;
         armed_high   <= 1'b1;
         standby      <= 1'b0;
      end
      else
      begin
         alarm_active <= next_alarm_active;
         armed_high   <= next_armed_high;
         standby      <= next_standby;
      end
   end

   // Output enable low pulls the open-drain pin low; the data
   // level stays low so only the enable ever moves.
   logic alarm_oe_b;
   logic next_alarm_oe_b;
   logic alarm_data;
   logic next_alarm_data;
   logic conv_run;
   logic next_conv_run;

   always_comb
   begin
      next_alarm_oe_b = next_alarm_pin;
      next_alarm_data = 1'b0;
      next_conv_run   = !next_standby;
   end

   // Pin drivers and the run flag, each straight from a flop.
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         alarm_oe_b <= 1'b1;
         alarm_data <= 1'b0;
         conv_run   <= 1'b1;
      end
      else
      begin
         alarm_oe_b <= next_alarm_oe_b;
         alarm_data <= next_alarm_data;
         conv_run   <= next_conv_run;
      end
   end

   assign rdata_o          = rdata;
   assign alarm_out_o      = alarm_data;
   assign alarm_out_oe_b_o = alarm_oe_b;
   assign settings_o       = settings;
   assign standby_o        = standby;
   assign conv_run_o       = conv_run;

endmodule

//--- tb/tsrs_regs_assertions.sv
`timescale 1ns/1ps
// Watches the register set ports for settings, read and alarm timing.
module tsrs_regs_assertions
   import tsrs_pkg::*;
(
   // Clock and reset.
   input  wire logic                 mclk_i,
   input  wire logic                 rst_b_i,
   // Watched ports.
   input  wire tsrs_pkg::tsrs_req_s  req_i,
   input  wire logic                 rd_busy_i,
   input  wire logic [15:0]          rdata_o,
   input  wire tsrs_pkg::tsrs_conv_s conv_i,
   input  wire logic                 conv_run_o,
   input  wire logic                 alarm_out_o,
   input  wire logic                 alarm_out_oe_b_o,
   input  wire logic [7:0]           settings_o,
   input  wire logic                 standby_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);

   // Register access checks.
   a_settings_wr: assert property (
      req_i.wr && req_i.sel == PTR_SETTINGS |=> settings_o ==
      ($past(req_i.wdata[7:0]) & SETTINGS_WR_MASK))
      else $error("settings write not stored masked");
   a_rsvd_zero: assert property (settings_o[7] == 1'b0)
      else $error("reserved settings bit set");
   a_cfg_read: assert property (
      req_i.rd && !req_i.wr && req_i.sel == PTR_SETTINGS
      |=> rdata_o == {8'h00, $past(settings_o)})
      else $error("settings read data wrong");
   a_temp_pad: assert property (
      req_i.rd && req_i.sel == PTR_MEASURED |=> rdata_o[6:0] == 7'h00)
      else $error("unused temperature bits not zero");
   a_rdata_hold: assert property (!req_i.rd |=> $stable(rdata_o))
      else $error("read data moved without a read");
   a_upper_rw: assert property (
      (req_i.wr && req_i.sel == PTR_UPPER) ##2
      (req_i.rd && req_i.sel == PTR_UPPER)
      |=> rdata_o == $past(req_i.wdata, 3))
      else $error("upper limit not read back");

   // Standby and alarm checks.
   a_standby_cause: assert property (
      $rose(standby_o) |-> settings_o[SHUTDOWN_CTL_BIT])
      else $error("standby without shutdown request");
   a_standby_exit: assert property (
      !settings_o[SHUTDOWN_CTL_BIT] |-> ##[0:2] !standby_o)
      else $error("standby kept after shutdown cleared");
   a_int_clear: assert property (
      settings_o[ALERT_TYPE_BIT] && !settings_o[OUTPUT_LEVEL_SEL_BIT]
      && !alarm_out_oe_b_o && req_i.rd && !conv_i.done
      && !$past(conv_i.done) && !$past(conv_i.done, 2)
      |-> ##[1:3] alarm_out_oe_b_o)
      else $error("interrupt alarm not cleared by read");

   // Main scenarios.
   c_standby: cover property ($rose(standby_o));
   c_alarm: cover property ($fell(alarm_out_oe_b_o));
   c_busy_done: cover property (rd_busy_i && conv_i.done);
endmodule

bind tsrs_regs tsrs_regs_assertions u_chk (
   .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req_i),
   .rd_busy_i(rd_busy_i), .rdata_o(rdata_o), .conv_i(conv_i),
   .conv_run_o(conv_run_o), .alarm_out_o(alarm_out_o),
   .alarm_out_oe_b_o(alarm_out_oe_b_o), .settings_o(settings_o),
   .standby_o(standby_o)
);

//--- tb/tsrs_host_model.sv
`timescale 1ns/1ps
// Host side of the register port: one request pulse per access.
module tsrs_host_model
   import tsrs_pkg::*;
(
   // Clock.
   input  wire logic          mclk_i,
   // Register port.
   input  wire logic [15:0]   rdata_i,
   output tsrs_pkg::tsrs_req_s req_o,
   output logic               rd_busy_o
);
   initial req_o = '0;
   initial rd_busy_o = 1'b0;

   // Pulses one request; read data is taken after the answering edge.
   task automatic access(input logic w, input logic [1:0] s,
      input logic [15:0] d, input logic raw, output logic [15:0] q);
      if (w && s == PTR_SETTINGS && !raw)
         d[7:5] = 3'h0;
      @(posedge mclk_i);
      #2 req_o = '{w, !w, s, d};
      @(posedge mclk_i);
      #2 req_o = '0;
      q = rdata_i;
   endtask

   // Marks a serial read cycle as in progress or finished.
   task automatic busy(input logic b);
      @(posedge mclk_i);
      #2 rd_busy_o = b;
   endtask
endmodule

//--- tb/tsrs_regs_tb_top.sv
`timescale 1ns/1ps
// Drives the register set through its host port and checks replies.
module tsrs_regs_tb_top;
   import tsrs_pkg::*;
   logic          mclk_i = 1'b0;
   logic          rst_b_i = 1'b0;
   tsrs_req_s     req;
   logic          rd_busy;
   logic [15:0]   rdata;
   tsrs_conv_s    conv = '0;
   logic          conv_run;
   logic          pin;
   logic          pin_drv;
   logic          standby;
   logic [7:0]    settings;
   logic [15:0]   q;
   int            n_fail = 0;
   int            compares = 0;
   localparam int NF [4] = '{1, 2, 4, 6};

   // Clock at 40 MHz.
   always #12.5 mclk_i = ~mclk_i;

   tsrs_regs dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req),
      .rd_busy_i(rd_busy), .rdata_o(rdata), .conv_i(conv),
      .conv_run_o(conv_run), .alarm_out_o(pin_drv), .alarm_out_oe_b_o(pin),
      .settings_o(settings), .standby_o(standby));
   tsrs_host_model host (.mclk_i(mclk_i), .rdata_i(rdata),
      .req_o(req), .rd_busy_o(rd_busy));

   // Comparisons count and report mismatches.
   task automatic chk_word(input logic [15:0] got, input logic [15:0] e);
      compares++;
      if (got !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: %h, expected %h", $time, got, e);
      end
   endtask
   task automatic chk_bit(input logic got, input logic e);
      chk_word({15'h0000, got}, {15'h0000, e});
   endtask

   // Bus and converter helpers.
   task automatic wr(input logic [1:0] s, input logic [15:0] d);
      host.access(1'b1, s, d, 1'b0, q);
   endtask
   task automatic rd_chk(input logic [1:0] s, input logic [15:0] e);
      host.access(1'b0, s, 16'h0000, 1'b0, q);
      chk_word(q, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask
   task automatic convert(input logic [8:0] v);
      @(posedge mclk_i);
      #2 conv = '{1'b1, v};
      @(posedge mclk_i);
      #2 conv.done = 1'b0;
      idle(4);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("compares %0d, n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog well beyond the expected run length.
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      n_fail++;
      end_of_test();
   end

   // Main sequence.
   initial
   begin
      repeat (16) @(posedge mclk_i);
      #2 rst_b_i = 1'b1;
      rd_chk(PTR_MEASURED, 16'h0000);
      rd_chk(PTR_SETTINGS, 16'h0000);
      rd_chk(PTR_LOWER, 16'h4B00);
      rd_chk(PTR_UPPER, 16'h5000);
      chk_bit(pin, 1'b1);
      chk_bit(pin_drv, 1'b0);
      // A careless host sets every bit, the reserved one included.
      host.access(1'b1, PTR_SETTINGS, 16'h00FF, 1'b1, q);
      rd_chk(PTR_SETTINGS, 16'h007F);
      chk_word({8'h00, settings}, 16'h007F);
      chk_bit(pin, 1'b0);
      wr(PTR_SETTINGS, 16'h0000);
      wr(PTR_MEASURED, 16'hFFFF);
      rd_chk(PTR_MEASURED, 16'h0000);
      convert(9'h032);
      rd_chk(PTR_MEASURED, 16'h1900);
      convert(9'h1CE);
      rd_chk(PTR_MEASURED, 16'hE700);
      wr(PTR_UPPER, 16'h197F);
      rd_chk(PTR_UPPER, 16'h197F);
      wr(PTR_LOWER, 16'h1400);
      // A conversion inside a read updates the alarm only.
      host.busy(1'b1);
      convert(9'h03C);
      host.busy(1'b0);
      chk_bit(pin, 1'b0);
      rd_chk(PTR_MEASURED, 16'hE700);
      convert(9'h00A);
      rd_chk(PTR_MEASURED, 16'h0500);
      chk_bit(pin, 1'b1);
      // Every fault count code in comparator behaviour.
      for (int c = 0; c < 4; c++)
      begin
         wr(PTR_SETTINGS, 16'(c << 3));
         repeat (NF[c] - 1) convert(9'h03C);
         chk_bit(pin, 1'b1);
         convert(9'h03C);
         chk_bit(pin, 1'b0);
         repeat (NF[c]) convert(9'h00A);
         chk_bit(pin, 1'b1);
      end
      // Active-high polarity releases the pin while the alarm is on.
      wr(PTR_SETTINGS, 16'h0004);
      convert(9'h03C);
      chk_bit(pin, 1'b1);
      convert(9'h00A);
      chk_bit(pin, 1'b0);
      // Interrupt behaviour: read clears, shutdown clears.
      wr(PTR_SETTINGS, 16'h0002);
      convert(9'h03C);
      chk_bit(pin, 1'b0);
      rd_chk(PTR_LOWER, 16'h1400);
      idle(3);
      chk_bit(pin, 1'b1);
      convert(9'h00A);
      chk_bit(pin, 1'b0);
      wr(PTR_SETTINGS, 16'h0003);
      convert(9'h020);
      chk_bit(pin, 1'b1);
      chk_bit(standby, 1'b1);
      chk_bit(conv_run, 1'b0);
      rd_chk(PTR_MEASURED, 16'h1000);
      wr(PTR_SETTINGS, 16'h0000);
      idle(3);
      chk_bit(standby, 1'b0);
      chk_bit(conv_run, 1'b1);
      end_of_test();
   end
endmodule
